/* design/rpp_pkg.sv */
// rpp_pkg.sv: constants, register map and types of the remote program parser.
// assumes a 10 MHz system clock and an apb master in front of the registers.
//
// Functional notes
// - listen-only with ren: obey data, trigger, clear, lockout
// - listen-only: ignore local, abort, serial poll
// - program string is keystrokes, in order
// - every key but local has a code
// - ignored punctuation dropped; inside code breaks it
// - error-set character shows error 24, raises srq
// - srq cleared outside; bad code dropped, parsing continues
// - lower case folded to upper case
// - foreign two-character codes ignored without error
// - remote group-off codes, no toggling
// - numbers: signed mantissa, point, signed exponent
// - leading point gets an inserted zero
// - mantissa digits past fifth taken as zero
// - free run refreshes results after each measurement
// - device clear or entering remote selects free run
// - hold suppresses display and bus output
// - serial poll in hold measures once
// - hold left on trigger codes, trigger, key, local
// - leaving hold refreshes display as cycle starts
// - immediate trigger measures once, holds result
// - restart on local, trigger, listen address, key
// - result read returns to hold
// - settled trigger waits settling time first
// - bus handshake withheld during triggered measurement
package rpp_pkg;

  // timing
  localparam int CLK_PERIOD_NS  = 100;
  localparam int SETTLE_TIME_US = 100;
  localparam int SETTLE_CYCLES  = (SETTLE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // number entry
  localparam int MANT_DIGITS = 5;
  localparam int EXP_DIGITS  = 2;

  // register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_DATA   = 8'h04;
  localparam logic [7:0] REG_MSG    = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_CMD    = 8'h10;
  localparam logic [7:0] REG_NUM    = 8'h14;
  localparam logic [7:0] REG_EXP    = 8'h18;
  localparam logic [7:0] REG_RESULT = 8'h1c;

  // control fields and reset value
  localparam int         CTRL_REN_BIT = 0;
  localparam int         CTRL_LON_BIT = 1;
  localparam logic [1:0] CTRL_RESET   = 2'h0;

  // status fields
  localparam int ST_MODE_LSB   = 0;
  localparam int ST_SRQ_BIT    = 3;
  localparam int ST_REMOTE_BIT = 4;
  localparam int ST_LOCK_BIT   = 5;
  localparam int ST_LISTEN_BIT = 6;
  localparam int ST_HELD_BIT   = 7;
  localparam int ST_ERR_LSB    = 8;

  // number register fields
  localparam int NUM_PTPOS_LSB = 20;
  localparam int NUM_NEG_BIT   = 23;
  localparam int NUM_PT_BIT    = 24;
  localparam int EXP_NEG_BIT   = 8;

  // error display value, bcd
  localparam logic [7:0] ERR_INVALID_CODE = 8'h24;

  // group-off outputs
  localparam int GRP_AVG    = 0;
  localparam int GRP_HIPASS = 1;
  localparam int GRP_LOPASS = 2;
  localparam int GRP_NOTCH  = 3;
  localparam int GRP_RATIO  = 4;
  localparam int GRP_N      = 5;

  // characters
  localparam logic [7:0] CH_0     = 8'h30;
  localparam logic [7:0] CH_1     = 8'h31;
  localparam logic [7:0] CH_2     = 8'h32;
  localparam logic [7:0] CH_3     = 8'h33;
  localparam logic [7:0] CH_A     = 8'h41;
  localparam logic [7:0] CH_E     = 8'h45;
  localparam logic [7:0] CH_H     = 8'h48;
  localparam logic [7:0] CH_L     = 8'h4c;
  localparam logic [7:0] CH_N     = 8'h4e;
  localparam logic [7:0] CH_O     = 8'h4f;
  localparam logic [7:0] CH_R     = 8'h52;
  localparam logic [7:0] CH_T     = 8'h54;
  localparam logic [7:0] CH_PLUS  = 8'h2b;
  localparam logic [7:0] CH_MINUS = 8'h2d;
  localparam logic [7:0] CH_POINT = 8'h2e;

  typedef enum logic [2:0] {
    TM_FREE, TM_HOLD, TM_SETTLE, TM_TRIG, TM_WAIT, TM_POLL
  } rpp_state_t;

  typedef enum logic [2:0] {
    CC_IGNORE, CC_ERROR, CC_DIGIT, CC_POINT, CC_SIGN, CC_ALPHA
  } rpp_cc_t;

  // bus message bits, msb first: bit 7 srq_clr .. bit 0 trigger
  typedef struct packed {
    logic srq_clr;
    logic listen_addr;
    logic poll;
    logic abort;
    logic gtl;
    logic llo;
    logic dev_clr;
    logic trigger;
  } rpp_msg_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] first;
    logic [7:0] second;
  } rpp_cmd_t;

  typedef struct packed {
    logic        active;
    logic        mneg;
    logic [19:0] mant;
    logic [2:0]  ndig;
    logic        pt_seen;
    logic [2:0]  pt_pos;
    logic        exp_mode;
    logic        eneg;
    logic [7:0]  expo;
    logic [1:0]  edig;
  } rpp_num_t;

endpackage

/* design/rpp_top.sv */
// rpp_top.sv: program string parser and trigger sequencer with apb registers.
// assumes bus messages and data bytes are handed in by software over apb,
// and a measurement engine that answers meas_start_o with meas_done_i.
//
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module rpp_top
  import rpp_pkg::*;
#(
  parameter int unsigned SETTLE_CNT = SETTLE_CYCLES
) (
  // clock and reset
  input  wire logic              mclk_i,
  input  wire logic              resetn_i,
  // apb slave
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [7:0]        paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  // front panel keys, one-cycle pulses
  input  wire logic              shift_key_i,
  input  wire logic              averaging_detector_key_i,
  input  wire logic              return_local_key_i,
  // measurement engine
  output logic                   meas_start_o,
  input  wire logic              meas_done_i,
  input  wire logic [31:0]       result_i,
  // instrument side
  output rpp_cmd_t               cmd_o,
  output logic [GRP_N-1:0]       grp_off_o,
  output logic                   disp_update_o,
  output logic                   bus_update_o,
  output logic                   srq_o,
  output logic [7:0]             err_code_o
);

  function automatic logic [7:0] fold_upper(input logic [7:0] c);
    logic [7:0] r;
    r = c;
    if (c >= 8'h61 && c <= 8'h7a) begin
      r = c - 8'h20;
    end
    return r;
  endfunction

  function automatic rpp_cc_t char_class(input logic [7:0] c);
    rpp_cc_t r;
    r = CC_IGNORE;
    if (c >= CH_0 && c <= 8'h39) begin
      r = CC_DIGIT;
    end else if (c == CH_POINT) begin
      r = CC_POINT;
    end else if (c == CH_PLUS || c == CH_MINUS) begin
      r = CC_SIGN;
    end else if (c inside {8'h40, 8'h42, 8'h45, 8'h47, 8'h49, 8'h4a, 8'h51, 8'h59,
                           8'h5a, 8'h5b, 8'h5c, 8'h5d, 8'h5e, 8'h7b, 8'h7c, 8'h7d,
                           8'h7e, 8'h7f}) begin
      r = CC_ERROR;
    end else if (c >= CH_A && c <= 8'h5a) begin
      r = CC_ALPHA;
    end
    return r;
  endfunction

  function automatic logic is_code(input logic [7:0] f, input logic [7:0] s,
                                   input logic [7:0] a, input logic [7:0] b,
                                   input logic [7:0] alt);
    return (f == a) && (s == b || s == alt);
  endfunction

  // register state
  logic [1:0]  ctrl_q;
  logic [31:0] prdata_q;
  logic        slverr_q;
  logic [31:0] result_q;
  logic        held_q;
  logic        remote_q;
  logic        lockout_q;
  logic        listen_q;
  logic        srq_q;
  logic [7:0]  err_q;
  logic        pend_q;
  logic [7:0]  pend_c_q;
  rpp_num_t    num_q;
  rpp_num_t    num_d;
  rpp_state_t  state_q;
  rpp_state_t  state_d;
  logic        busy_q;
  logic [15:0] settle_q;
  logic        start_d;

  // bus strobes
  logic        acc;
  logic        trig_busy;
  logic        wr_fire;
  logic        rd_fire;
  logic        data_fire;
  logic        msg_fire;
  rpp_msg_t    msg;
  logic        lon;

  // decoded events
  logic        byte_ok;
  logic [7:0]  ch;
  rpp_cc_t     cc;
  logic        is_exp;
  logic        code_done;
  logic        bad_char;
  logic        c_t0;
  logic        c_t1;
  logic        c_t2;
  logic        c_t3;
  logic        ev_gtl;
  logic        ev_poll;
  logic        ev_abort;
  logic        ev_key;
  logic        go_local;
  logic        enter_rmt;
  logic        result_rd;
  logic        done_ok;

  assign acc       = psel_i & penable_i;
  assign trig_busy = (state_q == TM_SETTLE) || (state_q == TM_TRIG);
  assign pready_o  = !(acc && pwrite_i && trig_busy &&
                       (paddr_i == REG_DATA || paddr_i == REG_MSG));
  assign wr_fire   = acc & pready_o & pwrite_i;
  assign rd_fire   = acc & pready_o & !pwrite_i;
  assign data_fire = wr_fire && (paddr_i == REG_DATA);
  assign msg_fire  = wr_fire && (paddr_i == REG_MSG);
  assign msg       = msg_fire ? rpp_msg_t'(pwdata_i[7:0]) : '0;
  assign lon       = ctrl_q[CTRL_LON_BIT];
  assign prdata_o  = prdata_q;
  assign pslverr_o = slverr_q;
  assign result_rd = rd_fire && (paddr_i == REG_RESULT);
  assign done_ok   = meas_done_i & busy_q;

  // listen-only with ren takes every byte
  assign byte_ok   = data_fire & ctrl_q[CTRL_REN_BIT] & (lon | listen_q);
  assign ch        = fold_upper(pwdata_i[7:0]);
  assign cc        = char_class(ch);
  assign is_exp    = num_q.active & !num_q.exp_mode & (ch == CH_E);
  assign code_done = byte_ok & pend_q & !is_exp & (cc == CC_ALPHA || cc == CC_DIGIT);
  assign bad_char  = byte_ok & !is_exp & (cc == CC_ERROR);
  assign c_t0      = code_done & is_code(pend_c_q, ch, CH_T, CH_0, CH_O);
  assign c_t1      = code_done & is_code(pend_c_q, ch, CH_T, CH_1, CH_1);
  assign c_t2      = code_done & is_code(pend_c_q, ch, CH_T, CH_2, CH_2);
  assign c_t3      = code_done & is_code(pend_c_q, ch, CH_T, CH_3, CH_3);

  assign ev_gtl    = msg.gtl & !lon;
  assign ev_abort  = msg.abort & !lon;
  assign ev_poll   = msg.poll & !lon;
  assign ev_key    = shift_key_i & averaging_detector_key_i & remote_q & !lockout_q;
  assign go_local  = remote_q & (ev_gtl | (return_local_key_i & !lockout_q) |
                                 !ctrl_q[CTRL_REN_BIT]);
  assign enter_rmt = !remote_q & ctrl_q[CTRL_REN_BIT] & (msg.listen_addr | (lon & data_fire));

  // apb registers
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      ctrl_q <= CTRL_RESET;
    end else if (wr_fire && paddr_i == REG_CTRL) begin
      ctrl_q <= pwdata_i[1:0];
    end
  end

  // read data sampled in the setup cycle
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      prdata_q <= 32'h0;
      slverr_q <= 1'b0;
    end else if (psel_i && !penable_i) begin
      prdata_q <= 32'h0;
      slverr_q <= 1'b0;
      case (paddr_i)
        REG_CTRL:   prdata_q[1:0] <= ctrl_q;
        REG_DATA:   ;
        REG_MSG:    ;
        REG_STATUS: begin
          prdata_q[ST_MODE_LSB +: 3] <= state_q;
          prdata_q[ST_SRQ_BIT]       <= srq_q;
          prdata_q[ST_REMOTE_BIT]    <= remote_q;
          prdata_q[ST_LOCK_BIT]      <= lockout_q;
          prdata_q[ST_LISTEN_BIT]    <= listen_q;
          prdata_q[ST_HELD_BIT]      <= held_q;
          prdata_q[ST_ERR_LSB +: 8]  <= err_q;
        end
        REG_CMD:    prdata_q[16:0] <= cmd_o;
        REG_NUM: begin
          prdata_q[19:0]                <= num_q.mant;
          prdata_q[NUM_PTPOS_LSB +: 3]  <= num_q.pt_pos;
          prdata_q[NUM_NEG_BIT]         <= num_q.mneg;
          prdata_q[NUM_PT_BIT]          <= num_q.pt_seen;
        end
        REG_EXP: begin
          prdata_q[7:0]       <= num_q.expo;
          prdata_q[EXP_NEG_BIT] <= num_q.eneg;
        end
        REG_RESULT: prdata_q <= result_q;
        default:    slverr_q <= 1'b1;
      endcase
    end
  end

  // remote, lockout and listen addressing
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      remote_q  <= 1'b0;
      lockout_q <= 1'b0;
      listen_q  <= 1'b0;
    end else begin
      if (go_local) begin
        remote_q <= 1'b0;
      end else if (enter_rmt) begin
        remote_q <= 1'b1;
      end
      if (!ctrl_q[CTRL_REN_BIT]) begin
        lockout_q <= 1'b0;
      end else if (msg.llo) begin
        lockout_q <= 1'b1;
      end
      if (msg.listen_addr) begin
        listen_q <= 1'b1;
      end else if (ev_abort) begin
        listen_q <= 1'b0;
      end
    end
  end

  // punctuation inside a code discards the first character
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      pend_q   <= 1'b0;
      pend_c_q <= 8'h00;
    end else if (byte_ok && !is_exp && cc != CC_ERROR) begin
      if (cc == CC_ALPHA && !pend_q) begin
        pend_q   <= 1'b1;
        pend_c_q <= ch;
      end else begin
        pend_q <= 1'b0;
      end
    end
  end

  always_comb begin
    rpp_num_t b;
    b     = num_q.active ? num_q : '0;
    num_d = num_q;
    if (byte_ok) begin
      if (is_exp) begin
        num_d.exp_mode = 1'b1;
      end else if (cc == CC_ALPHA && !pend_q) begin
        num_d.active = 1'b0;
      end else if ((cc == CC_POINT || cc == CC_SIGN) ||
                   (cc == CC_DIGIT && !pend_q)) begin
        num_d        = b;
        num_d.active = 1'b1;
        if (b.exp_mode) begin
          if (cc == CC_SIGN && b.edig == 2'h0) begin
            num_d.eneg = (ch == CH_MINUS);
          end else if (cc == CC_DIGIT && b.edig < 2'(EXP_DIGITS)) begin
            num_d.expo = {b.expo[3:0], ch[3:0]};
            num_d.edig = b.edig + 2'h1;
          end
        end else if (cc == CC_SIGN) begin
          if (b.ndig == 3'h0 && !b.pt_seen) begin
            num_d.mneg = (ch == CH_MINUS);
          end
        end else if (cc == CC_POINT) begin
          if (!b.pt_seen) begin
            num_d.pt_seen = 1'b1;
            if (b.ndig == 3'h0) begin
              num_d.ndig   = 3'h1;
              num_d.pt_pos = 3'h1;
            end
          end
        end else if (b.ndig < 3'(MANT_DIGITS)) begin
          num_d.mant = {b.mant[15:0], ch[3:0]};
          num_d.ndig = b.ndig + 3'h1;
          if (!b.pt_seen) begin
            num_d.pt_pos = b.pt_pos + 3'h1;
          end
        end else if (!b.pt_seen && b.pt_pos != 3'h7) begin
          num_d.pt_pos = b.pt_pos + 3'h1;
        end
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      num_q <= '0;
    end else begin
      num_q <= num_d;
    end
  end

  // every key code forwarded; unknown ones forwarded too, raising no error
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      cmd_o     <= '0;
      grp_off_o <= '0;
    end else begin
      cmd_o.valid <= code_done;
      if (code_done) begin
        cmd_o.first  <= pend_c_q;
        cmd_o.second <= ch;
      end
      grp_off_o[GRP_AVG]    <= code_done & is_code(pend_c_q, ch, CH_A, CH_0, CH_0);
      grp_off_o[GRP_HIPASS] <= code_done & is_code(pend_c_q, ch, CH_H, CH_0, CH_O);
      grp_off_o[GRP_LOPASS] <= code_done & is_code(pend_c_q, ch, CH_L, CH_0, CH_O);
      grp_off_o[GRP_NOTCH]  <= code_done & is_code(pend_c_q, ch, CH_N, CH_0, CH_O);
      grp_off_o[GRP_RATIO]  <= code_done & is_code(pend_c_q, ch, CH_R, CH_0, CH_0);
    end
  end

  // service request held until cleared, set wins
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      srq_q <= 1'b0;
      err_q <= 8'h00;
    end else begin
      srq_q <= bad_char | (srq_q & !(msg.dev_clr | msg.srq_clr | ev_poll));
      if (bad_char) begin
        err_q <= ERR_INVALID_CODE;
      end else if (msg.dev_clr) begin
        err_q <= 8'h00;
      end
    end
  end
  assign srq_o      = srq_q;
  assign err_code_o = err_q;

  // trigger sequencer
  always_comb begin
    state_d = state_q;
    // clear or remote entry gives free run
    if (msg.dev_clr || enter_rmt || go_local || !remote_q) begin
      state_d = TM_FREE;
    end else begin
      unique case (state_q)
        TM_FREE: begin
          if (c_t1) begin
            state_d = TM_HOLD;
          end else if (c_t2) begin
            state_d = TM_TRIG;
          end else if (c_t3 || msg.trigger) begin
            state_d = TM_SETTLE;
          end
        end
        TM_HOLD: begin
          if (c_t0) begin
            state_d = TM_FREE;
          end else if (c_t2) begin
            state_d = TM_TRIG;
          end else if (c_t3 || msg.trigger || ev_key) begin
            state_d = TM_SETTLE;
          end else if (ev_poll) begin
            state_d = TM_POLL;
          end
        end
        TM_SETTLE: begin
          if (settle_q == 16'h0) begin
            state_d = TM_TRIG;
          end
        end
        TM_TRIG: begin
          if (done_ok) begin
            state_d = TM_WAIT;
          end
        end
        TM_WAIT: begin
          if (c_t0) begin
            state_d = TM_FREE;
          end else if (c_t3 || msg.trigger || ev_key) begin
            state_d = TM_SETTLE;
          end else if (c_t2 || msg.listen_addr || (code_done && !c_t1)) begin
            state_d = TM_TRIG;
          end else if (result_rd || c_t1) begin
            state_d = TM_HOLD;
          end
        end
        TM_POLL: begin
          if (done_ok) begin
            state_d = TM_HOLD;
          end
        end
      endcase
    end
  end

  always_comb begin
    start_d = 1'b0;
    if (state_d == TM_FREE) begin
      start_d = !busy_q || (state_q != TM_FREE);
    end else if (state_d == TM_TRIG || state_d == TM_POLL) begin
      start_d = (state_d != state_q) || (state_q == TM_WAIT);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      state_q <= TM_FREE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      settle_q <= 16'h0;
    end else if (state_d == TM_SETTLE && state_q != TM_SETTLE) begin
      settle_q <= 16'(SETTLE_CNT - 1);
    end else if (settle_q != 16'h0) begin
      settle_q <= settle_q - 16'h1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      busy_q       <= 1'b0;
      meas_start_o <= 1'b0;
    end else begin
      meas_start_o <= start_d;
      if (start_d) begin
        busy_q <= 1'b1;
      end else if (meas_done_i) begin
        busy_q <= 1'b0;
      end
    end
  end

  // nothing reaches display or bus in hold
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      result_q      <= 32'h0;
      held_q        <= 1'b0;
      disp_update_o <= 1'b0;
      bus_update_o  <= 1'b0;
    end else begin
      // display refreshed as hold is left
      disp_update_o <= (done_ok && state_q != TM_HOLD) ||
                       (state_q == TM_HOLD && state_d != TM_HOLD);
      bus_update_o  <= done_ok && state_q != TM_HOLD;
      if (done_ok && state_q != TM_HOLD) begin
        result_q <= result_i;
      end
      if (done_ok && state_q != TM_HOLD) begin
        held_q <= 1'b1;
      end else if (result_rd) begin
        held_q <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

/* sim/rpp_top_monitor.sv */
// rpp_top_monitor.sv: port assertions for the parser and trigger sequencer.
// assumes it is bound to rpp_top and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module rpp_top_monitor
  import rpp_pkg::*;
#(
  parameter int unsigned SETTLE_CNT = SETTLE_CYCLES
) (
  input wire logic           mclk_i, resetn_i, psel_i, pwrite_i,
  input wire logic [7:0]     paddr_i,
  input wire logic           pready_o, meas_done_i, bus_update_o, srq_o,
  input wire rpp_cmd_t       cmd_o,
  input wire logic [GRP_N-1:0] grp_off_o,
  input wire logic [7:0]     err_code_o
);
  default clocking mon_cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  chk_reset_quiet: assert property (disable iff (1'b0)
    !resetn_i |=> !srq_o && err_code_o == 8'h00 && grp_off_o == '0 && !cmd_o.valid)
    else $error("outputs not cleared by reset");
  chk_err_shown: assert property ($rose(srq_o) |-> err_code_o == ERR_INVALID_CODE)
    else $error("service request without error 24");
  chk_srq_holds: assert property ($rose(srq_o) |-> srq_o [*2])
    else $error("service request dropped on its own");
  chk_cmd_pulse: assert property (cmd_o.valid |=> !cmd_o.valid)
    else $error("code strobe longer than one cycle");
  chk_cmd_upper: assert property (cmd_o.valid |-> !(cmd_o.first inside {[8'h61:8'h7a]})
    && !(cmd_o.second inside {[8'h61:8'h7a]}))
    else $error("lower case letter in decoded code");
  chk_grp_single: assert property (grp_off_o != '0 |-> $onehot(grp_off_o) ##1 grp_off_o == '0)
    else $error("group-off pulse malformed");
  chk_stall_only: assert property (!pready_o |-> psel_i && pwrite_i
    && (paddr_i == REG_DATA || paddr_i == REG_MSG))
    else $error("wait state outside a command write");
  chk_bus_cause: assert property ($rose(bus_update_o) |-> $past(meas_done_i)
    || $past(meas_done_i, 2))
    else $error("bus result refreshed without a measurement");
endmodule

bind rpp_top rpp_top_monitor #(.SETTLE_CNT(SETTLE_CNT)) rpp_top_monitor_i (.mclk_i, .resetn_i,
  .psel_i, .pwrite_i, .paddr_i, .pready_o, .meas_done_i, .bus_update_o, .srq_o, .cmd_o,
  .grp_off_o, .err_code_o);
`default_nettype wire

/* sim/rpp_meas_model.sv */
// rpp_meas_model.sv: measurement engine answering each start lat_i+1 cycles after it is sampled.
// assumes one-cycle start pulses; a new start restarts the measurement.
`timescale 1ns/10ps
`default_nettype none
module rpp_meas_model (
  input  wire logic        mclk_i,
  input  wire logic        resetn_i,
  input  wire logic        start_i,
  input  wire logic [3:0]  lat_i,
  output logic             done_o,
  output logic [31:0]      result_o
);
  logic        busy_q;
  logic [3:0]  cnt_q;
  logic [31:0] val_q;
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      busy_q <= 1'b0;
      cnt_q  <= 4'h0;
      val_q  <= 32'h0000_0100;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        busy_q <= 1'b1;
        cnt_q  <= lat_i;
      end else if (busy_q && cnt_q == 4'h0) begin
        busy_q <= 1'b0;
        done_o <= 1'b1;
        val_q  <= val_q + 32'h0000_0001;
      end else if (busy_q) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
  // result only meaningful with done
  assign result_o = done_o ? val_q : ~val_q;
endmodule
`default_nettype wire

/* sim/tb_remote_program_parser_trigger.sv */
// tb_remote_program_parser_trigger.sv: self-checking bench for rpp_top.
// assumes rpp_meas_model as engine; registers reached over apb.
`timescale 1ns/10ps
`default_nettype none
module tb_remote_program_parser_trigger;
  import rpp_pkg::*;
  typedef struct packed {logic [7:0] c0, c1; logic [31:0] cmd; logic [4:0] grp;} rpp_row_t;
  logic mclk_i = 1'b0, resetn_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic shift_key_i = 1'b0, averaging_detector_key_i = 1'b0, return_local_key_i = 1'b0, pe;
  logic [7:0] paddr_i = 8'h00, err_code_o;
  logic [31:0] pwdata_i = 32'h0, prdata_o, result_i, rd, res_q;
  logic pready_o, pslverr_o, meas_start_o, meas_done_i, disp_update_o, bus_update_o, srq_o;
  logic [3:0] lat = 4'h2;
  logic [4:0] grp_off_o, grp_seen = 5'h00, grp_exp = 5'h00;
  rpp_cmd_t cmd_o;
  int mismatches = 0, checks_done = 0, upd = 0, starts = 0, u0;
  rpp_row_t rows [6] = '{'{8'h6d, 8'h31, 32'h0000_4d31, 5'h00},
    '{8'h61, 8'h30, 32'h0000_4130, 5'h01}, '{8'h68, 8'h6f, 32'h0000_484f, 5'h02},
    '{8'h4c, 8'h30, 32'h0000_4c30, 5'h04}, '{8'h4e, 8'h4f, 32'h0000_4e4f, 5'h08},
    '{8'h72, 8'h30, 32'h0000_5230, 5'h10}};
  logic [7:0] bad [4] = '{8'h42, 8'h40, 8'h7f, 8'h5a};
  rpp_top #(.SETTLE_CNT(4)) rpp_top_i (.mclk_i, .resetn_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .shift_key_i,
    .averaging_detector_key_i, .return_local_key_i, .meas_start_o, .meas_done_i,
    .result_i, .cmd_o, .grp_off_o, .disp_update_o, .bus_update_o, .srq_o, .err_code_o);
  rpp_meas_model rpp_meas_model_i (.mclk_i, .resetn_i, .start_i(meas_start_o), .lat_i(lat),
    .done_o(meas_done_i), .result_o(result_i));
  always #50 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    grp_seen <= grp_seen | grp_off_o;
    upd <= upd + int'(disp_update_o | bus_update_o);
    starts <= starts + int'(meas_start_o);
    if (meas_done_i) res_q <= result_i;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
    checks_done++;
    if (seen !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, seen);
    end
  endtask
  task automatic end_sim;
    if (mismatches == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // one transfer, held until pready is taken high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk_i);
    {psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, w, a, d};
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge mclk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 300);
    rd = prdata_o;
    pe = pslverr_o;
    {psel_i, penable_i} <= 2'b00;
    if (n >= 300) begin
      mismatches++;
      end_sim();
    end
  endtask
  task automatic put(input logic [7:0] c);
    apb(1'b1, REG_DATA, {24'h0, c});
  endtask
  task automatic rdreg(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic msg(input int b);
    apb(1'b1, REG_MSG, 32'h1 << b);
  endtask
  task automatic state_is(input logic [31:0] m, input logic [31:0] e);
    rdreg(REG_STATUS);
    chk("status", rd & m, e);
  endtask
  task automatic putstr(input string t);
    for (int i = 0; i < t.len(); i++) put(t[i]);
  endtask
  initial begin
    repeat (10) @(posedge mclk_i);
    resetn_i <= 1'b1;
    state_is(32'hffff, 32'h0);
    rdreg(8'h40);
    chk("unmapped", {31'h0, pe}, 32'h1);
    apb(1'b1, REG_CTRL, 32'h3);
    foreach (rows[i]) begin
      put(rows[i].c0);
      put(rows[i].c1);
      rdreg(REG_CMD);
      chk("cmd", rd, rows[i].cmd);
      grp_exp = grp_exp | rows[i].grp;
      chk("grp", {27'h0, grp_seen}, {27'h0, grp_exp});
    end
    foreach (bad[i]) begin
      put(bad[i]);
      @(posedge mclk_i);
      @(negedge mclk_i);
      chk("srq", {srq_o, 23'h0, err_code_o}, {1'b1, 23'h0, ERR_INVALID_CODE});
      msg(7);
      @(negedge mclk_i);
      chk("srq_clr", {31'h0, srq_o}, 32'h0);
    end
    put(8'h4d);
    put(8'h32);
    rdreg(REG_CMD);
    chk("resume", rd, 32'h0000_4d32);
    putstr("-.5E-3");
    rdreg(REG_NUM);
    chk("num", rd, 32'h0190_0005);
    rdreg(REG_EXP);
    chk("exp", rd, 32'h0000_0103);
    putstr("MX1234567");
    rdreg(REG_NUM);
    chk("num_long", rd, 32'h0071_2345);
    putstr("M,3");
    rdreg(REG_CMD);
    chk("cmd_break", rd, 32'h0000_4d58);
    lat <= 4'h9;
    put(8'h54);
    put(8'h31);
    state_is(32'h7, 32'h1);
    u0 = upd;
    repeat (30) @(posedge mclk_i);
    chk("hold_quiet", upd, u0);
    msg(5);
    state_is(32'h7, 32'h1);
    put(8'h54);
    put(8'h32);
    put(8'h20);
    state_is(32'h87, 32'h84);
    rdreg(REG_RESULT);
    chk("result", rd, res_q);
    state_is(32'h7, 32'h1);
    msg(0);
    put(8'h20);
    state_is(32'h87, 32'h84);
    u0 = starts;
    msg(6);
    repeat (3) @(posedge mclk_i);
    chk("restart", starts, u0 + 1);
    put(8'h20);
    rdreg(REG_RESULT);
    @(posedge mclk_i);
    {shift_key_i, averaging_detector_key_i} <= 2'b11;
    @(posedge mclk_i);
    {shift_key_i, averaging_detector_key_i} <= 2'b00;
    put(8'h20);
    state_is(32'h87, 32'h84);
    u0 = starts;
    msg(2);
    repeat (3) @(posedge mclk_i);
    chk("keep", starts, u0);
    msg(1);
    state_is(32'h7, 32'h0);
    apb(1'b1, REG_CTRL, 32'h1);
    put(8'h54);
    put(8'h31);
    state_is(32'h7, 32'h1);
    u0 = starts;
    msg(5);
    repeat (3) @(posedge mclk_i);
    chk("poll", starts, u0 + 1);
    repeat (15) @(posedge mclk_i);
    state_is(32'h7, 32'h1);
    @(posedge mclk_i);
    return_local_key_i <= 1'b1;
    @(posedge mclk_i);
    return_local_key_i <= 1'b0;
    state_is(32'h37, 32'h31);
    msg(3);
    state_is(32'h17, 32'h0);
    end_sim();
  end
endmodule
`default_nettype wire
